/* rtl/fic_pkg.sv */
`default_nettype none
package fic_pkg;

  // Register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] FORCE_OFFSET = 8'h2f;
  localparam logic [7:0] STATUS_OFFSET = 8'h30;
  localparam logic [7:0] MASK_OFFSET = 8'h31;
  localparam logic [15:0] FORCE_RESET = 16'h0000;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;

  // Field positions, shared by force, status and mask registers
  localparam int BIT_CHECKSUM = 15;
  localparam int BIT_REFERENCE = 14;
  localparam int BIT_OT_ERROR = 13;
  localparam int BIT_OT_WARNING = 12;
  localparam int BIT_DIAG0_LOW = 0;
  localparam int NUM_DIAG = 5;
  localparam logic [15:0] FIELD_MASK = 16'hf3ff;

  // Serial output frame
  localparam int WORD_W = 16;
  localparam int CHECK_W = 8;
  localparam int FRAME_W = 24;
  localparam logic [7:0] CHECK_POLY = 8'h07;
  localparam logic [7:0] CHECK_INIT = 8'h00;
  localparam logic [4:0] FRAME_BITS = 5'h18;

  // Pin synchroniser lanes: chip select, link clock, three analog monitors
  localparam int SYNC_W = 5;
  localparam int SY_CS = 4;
  localparam int SY_SCLK = 3;
  localparam int SY_REF = 2;
  localparam int SY_OTERR = 1;
  localparam int SY_OTWARN = 0;
  localparam logic [4:0] SYNC_RESET = 5'h10;

  typedef enum {
    FIC_IDLE,
    FIC_SHIFT
  } fic_link_e;

endpackage

`default_nettype wire

/* rtl/fic_top.sv */
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module fic_top #(
  parameter int NUM_DIAG = fic_pkg::NUM_DIAG
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [fic_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [fic_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [fic_pkg::DATA_W-1:0] reg_rdata_o,
  // Serial link pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  // Word sent in each serial frame
  input wire logic [fic_pkg::WORD_W-1:0] tx_word_i,
  // Analog monitor pins
  input wire logic ref_fault_i,
  input wire logic overtemp_err_i,
  input wire logic overtemp_warn_i,
  // Diagnostic converter limit checks
  input wire logic [NUM_DIAG-1:0] diag_high_i,
  input wire logic [NUM_DIAG-1:0] diag_low_i,
  // Fault indications to status and alarm logic
  output logic ref_fault_o,
  output logic overtemp_err_o,
  output logic overtemp_warn_o,
  output logic [NUM_DIAG-1:0] diag_high_o,
  output logic [NUM_DIAG-1:0] diag_low_o,
  // Open-drain alarm and push-pull interrupt
  output logic alarm_n_o,
  output logic alarm_oe_o,
  output logic irq_o
);

  // Widths the register port, frame and synchroniser are built for
  if (NUM_DIAG != fic_pkg::NUM_DIAG) begin : g_check
    $error("fic_top serves exactly five diagnostic channels");
  end

  if (fic_pkg::DATA_W != 16) begin : g_check_data
    $error("fic_top needs a 16-bit register port");
  end

  if (fic_pkg::ADDR_W != 8) begin : g_check_addr
    $error("fic_top decodes an 8-bit register address");
  end

  if (fic_pkg::WORD_W != 16) begin : g_check_word
    $error("fic_top sends a 16-bit word in each frame");
  end

  if (fic_pkg::CHECK_W != 8) begin : g_check_crc
    $error("fic_top appends an 8-bit checksum");
  end

  if (fic_pkg::FRAME_W != fic_pkg::WORD_W + fic_pkg::CHECK_W) begin : g_check_frame
    $error("a frame is one word and one checksum byte");
  end

  if (fic_pkg::FRAME_BITS != fic_pkg::FRAME_W) begin : g_check_bits
    $error("frame bit count must match the frame width");
  end

  if (fic_pkg::SYNC_W != 5) begin : g_check_sync
    $error("synchroniser needs one lane per pin");
  end

  if (fic_pkg::SY_CS >= fic_pkg::SYNC_W || fic_pkg::SY_SCLK >= fic_pkg::SYNC_W ||
      fic_pkg::SY_REF >= fic_pkg::SYNC_W || fic_pkg::SY_OTERR >= fic_pkg::SYNC_W ||
      fic_pkg::SY_OTWARN >= fic_pkg::SYNC_W) begin : g_check_lanes
    $error("synchroniser lane outside the synchroniser");
  end

  // Register map and reset values
  if (fic_pkg::FORCE_OFFSET == fic_pkg::STATUS_OFFSET ||
      fic_pkg::FORCE_OFFSET == fic_pkg::MASK_OFFSET ||
      fic_pkg::STATUS_OFFSET == fic_pkg::MASK_OFFSET) begin : g_check_map
    $error("register offsets must differ");
  end

  // Nothing may be forced out of reset
  if (fic_pkg::FORCE_RESET != 16'h0000) begin : g_check_force
    $error("force register must reset to zero");
  end

  if ((fic_pkg::STATUS_RESET & ~fic_pkg::FIELD_MASK) != 16'h0000) begin : g_check_status
    $error("status reset value sets a reserved bit");
  end

  if ((fic_pkg::MASK_RESET & ~fic_pkg::FIELD_MASK) != 16'h0000) begin : g_check_mask
    $error("mask reset value sets a reserved bit");
  end

  // Field layout: the fixed bits below assume this map
  if (fic_pkg::BIT_CHECKSUM != 15 || fic_pkg::BIT_REFERENCE != 14 ||
      fic_pkg::BIT_OT_ERROR != 13 || fic_pkg::BIT_OT_WARNING != 12) begin : g_check_top
    $error("checksum and analog fields must sit in bits 15 to 12");
  end

  if (fic_pkg::BIT_DIAG0_LOW + 2 * NUM_DIAG > 10) begin : g_check_diag
    $error("diagnostic fields run into the reserved bits");
  end

  if (fic_pkg::FIELD_MASK[11:10] != 2'b00) begin : g_check_reserved
    $error("reserved bits must stay out of status and mask");
  end

  // Idle pin levels, so that no false edge follows reset
  if (fic_pkg::SYNC_RESET[fic_pkg::SY_CS] != 1'b1) begin : g_check_cs_idle
    $error("chip select lane must reset high");
  end

  if (fic_pkg::SYNC_RESET[fic_pkg::SY_SCLK] != 1'b0) begin : g_check_sclk_idle
    $error("link clock lane must reset low");
  end

  typedef struct packed {
    logic [15:0] force_bits;
    logic [15:0] status;
    logic [15:0] mask;
    logic [15:0] rdata;
    logic [fic_pkg::SYNC_W-1:0] sync1;
    logic [fic_pkg::SYNC_W-1:0] sync2;
    logic [fic_pkg::SYNC_W-1:0] sync3;
    logic [fic_pkg::SYNC_W-1:0] filt;
    logic [15:0] eff_prev;
    logic [15:0] eff_out;
    logic [fic_pkg::FRAME_W-1:0] shreg;
    logic [4:0] bitcnt;
    fic_pkg::fic_link_e link;
    logic sdo;
    logic sdo_oe;
    logic alarm_oe;
    logic irq;
  } fic_state_s;

  fic_state_s cur;
  fic_state_s nxt;
  logic [15:0] eff;
  logic [15:0] detected;
  logic [fic_pkg::CHECK_W-1:0] check_byte;

  // Bitwise checksum over the frame word, most significant bit first
  function automatic logic [7:0] fic_checksum(input logic [15:0] word);
    logic [7:0] c;
    c = fic_pkg::CHECK_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (c[7] ^ word[i]) begin
        c = {c[6:0], 1'b0} ^ fic_pkg::CHECK_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  // Genuinely detected faults, laid out like the force register
  always_comb begin
    detected = 16'h0000;
    detected[fic_pkg::BIT_REFERENCE] = cur.filt[fic_pkg::SY_REF];
    detected[fic_pkg::BIT_OT_ERROR] = cur.filt[fic_pkg::SY_OTERR];
    detected[fic_pkg::BIT_OT_WARNING] = cur.filt[fic_pkg::SY_OTWARN];
    for (int i = 0; i < NUM_DIAG; i++) begin
      detected[fic_pkg::BIT_DIAG0_LOW + 2 * i] = diag_low_i[i];
      detected[fic_pkg::BIT_DIAG0_LOW + 2 * i + 1] = diag_high_i[i];
    end
  end

  assign eff[fic_pkg::BIT_REFERENCE] =
    detected[fic_pkg::BIT_REFERENCE] | cur.force_bits[fic_pkg::BIT_REFERENCE];
  assign eff[fic_pkg::BIT_OT_ERROR] =
    detected[fic_pkg::BIT_OT_ERROR] | cur.force_bits[fic_pkg::BIT_OT_ERROR];
  assign eff[fic_pkg::BIT_OT_WARNING] =
    detected[fic_pkg::BIT_OT_WARNING] | cur.force_bits[fic_pkg::BIT_OT_WARNING];
  assign eff[fic_pkg::BIT_CHECKSUM] = 1'b0;
  assign eff[11:10] = 2'b00;

  // An OR with zero passes the detected fault unchanged
  for (genvar g = 0; g < NUM_DIAG; g++) begin : g_diag
    assign eff[fic_pkg::BIT_DIAG0_LOW + 2 * g] =
      detected[fic_pkg::BIT_DIAG0_LOW + 2 * g] |
      cur.force_bits[fic_pkg::BIT_DIAG0_LOW + 2 * g];
    assign eff[fic_pkg::BIT_DIAG0_LOW + 2 * g + 1] =
      detected[fic_pkg::BIT_DIAG0_LOW + 2 * g + 1] |
      cur.force_bits[fic_pkg::BIT_DIAG0_LOW + 2 * g + 1];
  end

  assign check_byte = cur.force_bits[fic_pkg::BIT_CHECKSUM] ?
    ~fic_checksum(tx_word_i) : fic_checksum(tx_word_i);

  always_comb begin
    logic [15:0] events;
    logic [15:0] clear;
    logic cs_fall;
    logic sclk_fall;
    events = 16'h0000;
    clear = 16'h0000;
    cs_fall = 1'b0;
    sclk_fall = 1'b0;
    nxt = cur;

    // Three-stage pin synchroniser; a change counts once stages two and three agree
    nxt.sync1[fic_pkg::SY_CS] = cs_n_i;
    nxt.sync1[fic_pkg::SY_SCLK] = sclk_i;
    nxt.sync1[fic_pkg::SY_REF] = ref_fault_i;
    nxt.sync1[fic_pkg::SY_OTERR] = overtemp_err_i;
    nxt.sync1[fic_pkg::SY_OTWARN] = overtemp_warn_i;
    nxt.sync2 = cur.sync1;
    nxt.sync3 = cur.sync2;
    for (int i = 0; i < fic_pkg::SYNC_W; i++) begin
      if (cur.sync2[i] == cur.sync3[i]) begin
        nxt.filt[i] = cur.sync3[i];
      end
    end
    cs_fall = cur.filt[fic_pkg::SY_CS] & ~nxt.filt[fic_pkg::SY_CS];
    sclk_fall = cur.filt[fic_pkg::SY_SCLK] & ~nxt.filt[fic_pkg::SY_SCLK];

    // Register reads: data stand in the cycle after the strobe only
    nxt.rdata = 16'h0000;
    if (reg_rd_i) begin
      case (reg_addr_i)
        fic_pkg::FORCE_OFFSET: nxt.rdata = cur.force_bits;
        fic_pkg::STATUS_OFFSET: nxt.rdata = cur.status;
        fic_pkg::MASK_OFFSET: nxt.rdata = cur.mask;
        default: nxt.rdata = fic_pkg::UNMAPPED_READ;
      endcase
    end

    if (reg_wr_i) begin
      case (reg_addr_i)
        fic_pkg::FORCE_OFFSET: nxt.force_bits = reg_wdata_i;
        fic_pkg::STATUS_OFFSET: clear = reg_wdata_i & fic_pkg::FIELD_MASK;
        fic_pkg::MASK_OFFSET: nxt.mask = reg_wdata_i & fic_pkg::FIELD_MASK;
        default: ;
      endcase
    end

    // Forced analog and diagnostic faults feed indications for as long as set; a forced checksum fault does not
    nxt.eff_out = eff;
    nxt.eff_prev = eff;
    nxt.alarm_oe = |eff;

    // Serial frame: word then checksum, shifted on falling link clock
    case (cur.link)
      fic_pkg::FIC_IDLE: begin
        nxt.sdo_oe = 1'b0;
        nxt.sdo = 1'b0;
        if (cs_fall) begin
          nxt.shreg = {tx_word_i, check_byte};
          nxt.sdo = tx_word_i[fic_pkg::WORD_W-1];
          nxt.bitcnt = 5'h00;
          nxt.link = fic_pkg::FIC_SHIFT;
          nxt.sdo_oe = 1'b1;
          events[fic_pkg::BIT_CHECKSUM] = cur.force_bits[fic_pkg::BIT_CHECKSUM];
        end
      end
      fic_pkg::FIC_SHIFT: begin
        if (nxt.filt[fic_pkg::SY_CS]) begin
          nxt.link = fic_pkg::FIC_IDLE;
          nxt.sdo_oe = 1'b0;
          nxt.sdo = 1'b0;
        end else if (sclk_fall && cur.bitcnt != fic_pkg::FRAME_BITS) begin
          nxt.shreg = {cur.shreg[fic_pkg::FRAME_W-2:0], 1'b0};
          nxt.sdo = cur.shreg[fic_pkg::FRAME_W-2];
          nxt.bitcnt = cur.bitcnt + 5'h01;
        end else if (sclk_fall) begin
          // Edges past the last bit keep the line low
          nxt.sdo = 1'b0;
        end
      end
      default: begin
        nxt.link = fic_pkg::FIC_IDLE;
        nxt.sdo_oe = 1'b0;
      end
    endcase

    // Sticky status: rising fault edges; a set wins over a clear
    events = events | (eff & ~cur.eff_prev);
    nxt.status = ((cur.status & ~clear) | events) & fic_pkg::FIELD_MASK;
    nxt.irq = |(nxt.status & nxt.mask);
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cur.force_bits <= fic_pkg::FORCE_RESET;
      cur.status <= fic_pkg::STATUS_RESET;
      cur.mask <= fic_pkg::MASK_RESET;
      cur.rdata <= 16'h0000;
      cur.sync1 <= fic_pkg::SYNC_RESET;
      cur.sync2 <= fic_pkg::SYNC_RESET;
      cur.sync3 <= fic_pkg::SYNC_RESET;
      cur.filt <= fic_pkg::SYNC_RESET;
      cur.eff_prev <= 16'h0000;
      cur.eff_out <= 16'h0000;
      cur.shreg <= '0;
      cur.bitcnt <= 5'h00;
      cur.link <= fic_pkg::FIC_IDLE;
      cur.sdo <= 1'b0;
      cur.sdo_oe <= 1'b0;
      cur.alarm_oe <= 1'b0;
      cur.irq <= 1'b0;
    end else begin
      cur <= nxt;
    end
  end

  assign reg_rdata_o = cur.rdata;
  assign sdo_o = cur.sdo;
  assign sdo_oe_o = cur.sdo_oe;
  assign ref_fault_o = cur.eff_out[fic_pkg::BIT_REFERENCE];
  assign overtemp_err_o = cur.eff_out[fic_pkg::BIT_OT_ERROR];
  assign overtemp_warn_o = cur.eff_out[fic_pkg::BIT_OT_WARNING];
  for (genvar o = 0; o < NUM_DIAG; o++) begin : g_out
    assign diag_low_o[o] = cur.eff_out[fic_pkg::BIT_DIAG0_LOW + 2 * o];
    assign diag_high_o[o] = cur.eff_out[fic_pkg::BIT_DIAG0_LOW + 2 * o + 1];
  end
  assign alarm_n_o = 1'b0;
  assign alarm_oe_o = cur.alarm_oe;
  assign irq_o = cur.irq;

endmodule

`default_nettype wire

/* tb/fic_host.sv */
`timescale 1ns/10ps
`default_nettype none
module fic_host (
  // Serial pins
  input wire logic sdo_i,
  input wire logic sdo_oe_i,
  output logic cs_n_o,
  output logic sclk_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
  end
  task automatic frame(input realtime hp, output logic [23:0] f);
    // Step off the system clock edge before touching the pins
    #2;
    cs_n_o = 1'b0;
    #100;
    for (int i = 23; i >= 0; i--) begin
      sclk_o = 1'b1;
      f[i] = sdo_oe_i ? sdo_i : 1'bx;
      #(hp) sclk_o = 1'b0;
      #(hp);
    end
    cs_n_o = 1'b1;
  endtask
endmodule
`default_nettype wire

/* tb/fic_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module fic_monitor #(
  parameter int NUM_DIAG = 5
) (
  // Clock, reset, registers
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  // Pins and fault paths
  input wire logic cs_n_i,
  input wire logic sdo_oe_o,
  input wire logic ref_fault_o,
  input wire logic overtemp_err_o,
  input wire logic overtemp_warn_o,
  input wire logic [NUM_DIAG-1:0] diag_high_i,
  input wire logic [NUM_DIAG-1:0] diag_low_i,
  input wire logic [NUM_DIAG-1:0] diag_high_o,
  input wire logic [NUM_DIAG-1:0] diag_low_o,
  input wire logic alarm_n_o,
  input wire logic alarm_oe_o
);
  // Shadow of the force register
  logic [15:0] frc;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      frc <= 16'h0000;
    end else if (reg_wr_i && reg_addr_i == 8'h2f) begin
      frc <= reg_wdata_i;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence sel_s;
    $fell(cs_n_i) ##1 !cs_n_i [*5];
  endsequence
  sequence desel_s;
    cs_n_i [*5];
  endsequence
  alarm_low_a: assert property (!alarm_n_o) else $error("alarm high");
  alarm_any_a: assert property (alarm_oe_o == (|{diag_low_o, diag_high_o, ref_fault_o,
    overtemp_err_o, overtemp_warn_o})) else $error("alarm mismatch");
  diag_low_a: assert property (1 |=> diag_low_o == ($past(diag_low_i) |
    $past({frc[8], frc[6], frc[4], frc[2], frc[0]}))) else $error("diag low");
  diag_high_a: assert property (1 |=> diag_high_o == ($past(diag_high_i) |
    $past({frc[9], frc[7], frc[5], frc[3], frc[1]}))) else $error("diag high");
  force_read_a: assert property (reg_rd_i && reg_addr_i == 8'h2f |=>
    reg_rdata_o == frc) else $error("force readback");
  rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000) else $error("rdata");
  sdo_drive_a: assert property (sel_s |-> sdo_oe_o) else $error("sdo not driven");
  sdo_release_a: assert property (desel_s |-> !sdo_oe_o) else $error("sdo driven");
endmodule
bind fic_top fic_monitor #(.NUM_DIAG(NUM_DIAG)) fic_monitor_inst (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .cs_n_i(cs_n_i), .sdo_oe_o(sdo_oe_o),
  .ref_fault_o(ref_fault_o), .overtemp_err_o(overtemp_err_o),
  .overtemp_warn_o(overtemp_warn_o), .diag_high_i(diag_high_i),
  .diag_low_i(diag_low_i), .diag_high_o(diag_high_o), .diag_low_o(diag_low_o),
  .alarm_n_o(alarm_n_o), .alarm_oe_o(alarm_oe_o)
);
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic sys_clk_i, resetn_i, reg_wr_i, reg_rd_i, sdo_o, sdo_oe_o, cs_n_i, sclk_i, rd_d;
  logic ref_fault_i, overtemp_err_i, overtemp_warn_i, ref_fault_o, overtemp_err_o;
  logic overtemp_warn_o, alarm_n_o, alarm_oe_o, irq_o;
  logic [7:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, tx_word_i, f;
  logic [4:0] diag_high_i, diag_low_i, diag_high_o, diag_low_o;
  logic [23:0] fr;
  logic [31:0] seed;
  logic [15:0] exp_q[$];
  int failures, checked;
  fic_top fic_top_inst (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .cs_n_i(cs_n_i), .sclk_i(sclk_i), .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o), .tx_word_i(tx_word_i), .ref_fault_i(ref_fault_i),
    .overtemp_err_i(overtemp_err_i), .overtemp_warn_i(overtemp_warn_i),
    .diag_high_i(diag_high_i), .diag_low_i(diag_low_i), .ref_fault_o(ref_fault_o),
    .overtemp_err_o(overtemp_err_o), .overtemp_warn_o(overtemp_warn_o),
    .diag_high_o(diag_high_o), .diag_low_o(diag_low_o), .alarm_n_o(alarm_n_o),
    .alarm_oe_o(alarm_oe_o), .irq_o(irq_o)
  );
  fic_host fic_host_inst (.sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o), .cs_n_o(cs_n_i), .sclk_o(sclk_i));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] crc(input logic [15:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction
  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic faults(input logic [15:0] v);
    logic [4:0] lo, hi;
    logic [2:0] an;
    for (int k = 0; k < 5; k++) begin
      lo[k] = v[2*k] | diag_low_i[k];
      hi[k] = v[2*k+1] | diag_high_i[k];
    end
    an = v[14:12] | {ref_fault_i, overtemp_err_i, overtemp_warn_i};
    check(diag_low_o, lo, "diag low");
    check(diag_high_o, hi, "diag high");
    check({ref_fault_o, overtemp_err_o, overtemp_warn_o}, an, "analog");
    check(alarm_oe_o, |{lo, hi, an}, "alarm");
    check(alarm_n_o, 1'b0, "alarm level");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    failures++;
    tally_and_finish();
  end
  // Read results arrive one cycle after the strobe
  always @(posedge sys_clk_i) begin
    if (rd_d) check(reg_rdata_o, exp_q.pop_front(), "rdata");
    rd_d <= reg_rd_i;
  end
  initial begin
    {resetn_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, tx_word_i} = '0;
    {ref_fault_i, overtemp_err_i, overtemp_warn_i, diag_high_i, diag_low_i} = '0;
    seed = 32'h769567e4;
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    @(posedge sys_clk_i);
    rd(8'h2f, 16'h0000);
    rd(fic_pkg::STATUS_OFFSET, 16'h0000);
    rd(fic_pkg::MASK_OFFSET, 16'h0000);
    rd(8'h00, fic_pkg::UNMAPPED_READ);
    $display("reset test done");
    for (int i = 0; i < 16; i++) begin
      f = 16'h0001 << i;
      wr(8'h2f, f);
      rd(8'h2f, f);
      faults(f);
    end
    repeat (6) begin
      seed = lfsr(seed);
      {diag_low_i, diag_high_i, ref_fault_i, overtemp_err_i, overtemp_warn_i} <= seed[12:0];
      f = seed[31:16];
      wr(8'h2f, f);
      repeat (5) @(posedge sys_clk_i);
      faults(f);
    end
    $display("force test done");
    {diag_low_i, diag_high_i, ref_fault_i, overtemp_err_i, overtemp_warn_i} <= '0;
    wr(8'h2f, 16'h0000);
    repeat (5) @(posedge sys_clk_i);
    wr(fic_pkg::STATUS_OFFSET, 16'hffff);
    rd(fic_pkg::STATUS_OFFSET, 16'h0000);
    wr(fic_pkg::MASK_OFFSET, 16'h0001);
    check(irq_o, 1'b0, "irq idle");
    wr(8'h2f, 16'h0003);
    repeat (3) @(posedge sys_clk_i);
    check(irq_o, 1'b1, "irq set");
    wr(8'h2f, 16'h0000);
    rd(fic_pkg::STATUS_OFFSET, 16'h0003);
    wr(fic_pkg::STATUS_OFFSET, 16'h0001);
    rd(fic_pkg::STATUS_OFFSET, 16'h0002);
    check(irq_o, 1'b0, "irq cleared");
    $display("interrupt test done");
    for (int j = 0; j < 2; j++) begin
      seed = lfsr(seed);
      tx_word_i <= seed[15:0];
      wr(8'h2f, {j[0], 15'h0000});
      fic_host_inst.frame(62.5, fr);
      check(fr, {tx_word_i, crc(tx_word_i) ^ {8{j[0]}}}, "frame");
      repeat (6) @(posedge sys_clk_i);
      check(sdo_oe_o, 1'b0, "sdo released");
    end
    $display("frame test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
